// ---- include/awsc_pkg.sv ----
package awsc_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [3:0] AWSC_OFS_WAIT_CTRL = 4'h0;
	localparam logic [3:0] AWSC_OFS_ACCESS_CTRL = 4'h4;
	localparam logic [3:0] AWSC_OFS_STATUS = 4'h8;
	localparam int AWSC_A6_POS = 26;
	localparam int AWSC_A5_POS = 23;
	localparam int AWSC_A3_POS = 13;
	localparam logic [31:0] AWSC_WAIT_CTRL_RESET = 32'h1FC0_E000;
	localparam logic [31:0] AWSC_WAIT_CTRL_MASK = 32'h1F80_E000;
	localparam logic [31:0] AWSC_DEAD_VALUE = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Access control fields: start bit, area, area-3 interface, burst
	// ----------------------------------------------------------------
	localparam int AWSC_START_POS = 0;
	localparam int AWSC_AREA_POS = 4;
	localparam int AWSC_IF_POS = 8;
	localparam int AWSC_BURST_POS = 12;

	typedef enum logic [1:0] {
		AWSC_AREA3,
		AWSC_AREA5,
		AWSC_AREA6,
		AWSC_AREA_NONE
	} awsc_area_type;

	typedef enum logic [1:0] {
		AWSC_IF_SRAM,
		AWSC_IF_MULTIPLEXED,
		AWSC_IF_SDRAM,
		AWSC_IF_RESERVED
	} awsc_if_type;

	typedef enum logic [1:0] {
		AWSC_IDLE,
		AWSC_WAIT,
		AWSC_READY
	} awsc_state_type;

endpackage

// ---- include/awsc_wait_if.sv ----
`timescale 1ns/1ps
interface awsc_wait_if;
	import awsc_pkg::*;
	logic [2:0] code;
	awsc_area_type area;
	awsc_if_type if_kind;
	logic first_access;
	logic [3:0] wait_cycles;
	logic ready_enable;
	modport decoder (input code, input area, input if_kind, input first_access, output wait_cycles, output ready_enable);
	modport user (output code, output area, output if_kind, output first_access, input wait_cycles, input ready_enable);
endinterface

// ---- rtl/awsc_decode.sv ----
`timescale 1ns/1ps
module awsc_decode
	import awsc_pkg::*;
(
	awsc_wait_if.decoder dec
);

	// ----------------------------------------------------------------
	// Code to wait count mapping
	// ----------------------------------------------------------------
	wire scaled_map = (dec.area != AWSC_AREA6);
	wire code_zero = (dec.code == 3'h0);
	wire [3:0] linear_count = {1'b0, dec.code};
	wire [3:0] scaled_count = dec.code[2] ? 4'(({2'b00, dec.code[1:0]} + 4'h2) * 4'h3) : {2'b00, dec.code[1:0]};
	wire pitch_only_later = (dec.area == AWSC_AREA6) && dec.first_access;
	wire sdram_area3 = (dec.area == AWSC_AREA3) && (dec.if_kind == AWSC_IF_SDRAM);

	assign dec.wait_cycles = pitch_only_later ? 4'h0 : (scaled_map ? scaled_count : linear_count); // [RQ1] [RQ2] [RQ3] [RQ6]
	assign dec.ready_enable = !code_zero && !pitch_only_later && !sdram_area3; // [RQ2] [RQ4] [RQ6] [RQ7]

endmodule

// ---- rtl/awsc_top.sv ----
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// [RQ1] Area-6 burst pitch field, reset all ones, inserts code value waits directly.
// [RQ2] Pitch waits only for second and later burst accesses; code zero ignores ready.
// [RQ3] Area-5 wait field, reset all ones, maps to 0,1,2,3,6,9,12,15 waits.
// [RQ4] Area-5 ready input ignored for code zero, sampled otherwise.
// [RQ5] Area-3 wait field at bits 15 to 13, reset all ones.
// [RQ6] Area-3 SRAM codes give 0,1,2,3,6,9,12,15 waits; ready off only at zero.
// [RQ7] Wait input used for area 3 under SRAM and multiplexed, ignored under SDRAM.
// [RQ8] External part holds ready inactive to stretch the access until data valid.
module awsc_top
	import awsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_ready_n,
	output logic access_active,
	output logic access_done
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] area_wait_control;
	logic [1:0] acc_area;
	logic [1:0] acc_if;
	logic [4:0] acc_burst;
	logic [4:0] beat;
	logic [3:0] count;
	logic [4:0] next_beat;
	logic [3:0] next_count;
	logic ack;
	awsc_state_type state;
	awsc_state_type next_state;
	awsc_wait_if wif();

	awsc_decode u_decode (
		.dec(wif)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_req = avs_read || avs_write;
	wire access_write = avs_write && !ack;
	wire read_write = avs_read && !ack;
	wire sel_ctrl = (avs_address == AWSC_OFS_WAIT_CTRL);
	wire sel_access = (avs_address == AWSC_OFS_ACCESS_CTRL);
	wire sel_status = (avs_address == AWSC_OFS_STATUS);
	wire start_req = access_write && sel_access && avs_writedata[AWSC_START_POS] && (state == AWSC_IDLE);
	wire [1:0] req_area = avs_writedata[AWSC_AREA_POS +: 2];
	wire [1:0] req_if = avs_writedata[AWSC_IF_POS +: 2];
	wire [4:0] req_burst = {1'b0, avs_writedata[AWSC_BURST_POS +: 4]};

	// ----------------------------------------------------------------
	// Wait field selection
	// ----------------------------------------------------------------
	// The decoder sees the requested area while a start is taken, so the first count fits the new access.
	wire [2:0] a6_code = area_wait_control[AWSC_A6_POS +: 3];
	wire [2:0] a5_code = area_wait_control[AWSC_A5_POS +: 3];
	wire [2:0] a3_code = area_wait_control[AWSC_A3_POS +: 3];
	wire [1:0] cur_area = start_req ? req_area : acc_area;
	wire [1:0] cur_if = start_req ? req_if : acc_if;
	wire cur_is_a6 = (cur_area == 2'(AWSC_AREA6));
	wire cur_is_a5 = (cur_area == 2'(AWSC_AREA5));
	wire [2:0] sel_code = cur_is_a6 ? a6_code : (cur_is_a5 ? a5_code : a3_code);
	wire ready_seen = !wif.ready_enable || !ext_ready_n; // [RQ8]
	wire last_beat = (beat >= acc_burst);
	wire beat_end = (state == AWSC_READY) && ready_seen;
	wire more_beats = beat_end && !last_beat;
	wire enter_wait = start_req || more_beats;

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	wire [31:0] status_word = {24'h0, 3'h0, access_active, count};
	wire [31:0] access_word = {16'h0, acc_burst[3:0], 2'h0, acc_if, 2'h0, acc_area, 4'h0};
	wire [31:0] next_readdata = sel_ctrl ? area_wait_control : (sel_access ? access_word : (sel_status ? status_word : AWSC_DEAD_VALUE));

	assign wif.code = sel_code;
	assign wif.area = awsc_area_type'(cur_area);
	assign wif.if_kind = awsc_if_type'(cur_if);
	// Only a start from idle is a first access; every count loaded from the ready state is a later beat.
	assign wif.first_access = (state == AWSC_IDLE); // [RQ2]
	assign avs_waitrequest = bus_req && !ack;
	assign access_active = (state != AWSC_IDLE);

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			AWSC_IDLE: begin
				if (start_req) begin
					next_state = AWSC_WAIT;
				end
			end
			AWSC_WAIT: begin
				if (count == 4'h0) begin
					next_state = AWSC_READY;
				end
			end
			AWSC_READY: begin
				if (ready_seen && last_beat) begin // [RQ4] [RQ7]
					next_state = AWSC_IDLE;
				end else if (ready_seen) begin
					next_state = AWSC_WAIT;
				end
			end
			default: begin
				next_state = AWSC_IDLE;
			end
		endcase
	end

	always_comb begin
		next_beat = beat;
		if (state == AWSC_IDLE) begin
			next_beat = 5'h0;
		end else if (beat_end) begin
			next_beat = beat + 5'h1;
		end
	end

	always_comb begin
		next_count = count;
		if (enter_wait) begin
			next_count = wif.wait_cycles; // [RQ1] [RQ2] [RQ3] [RQ6]
		end else if (state == AWSC_WAIT && count != 4'h0) begin
			next_count = count - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= AWSC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 4'h0;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			beat <= 5'h0;
		end else begin
			beat <= next_beat;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			access_done <= 1'b0;
		end else begin
			access_done <= beat_end && last_beat;
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= bus_req && !ack;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0;
		end else if (read_write) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			area_wait_control <= AWSC_WAIT_CTRL_RESET; // [RQ1] [RQ3] [RQ5]
		end else if (access_write && sel_ctrl) begin
			area_wait_control <= avs_writedata & AWSC_WAIT_CTRL_MASK; // [RQ5]
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_area <= 2'h0;
		end else if (start_req) begin
			acc_area <= req_area;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_if <= 2'h0;
		end else if (start_req) begin
			acc_if <= req_if;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_burst <= 5'h0;
		end else if (start_req) begin
			acc_burst <= req_burst;
		end
	end

endmodule

// ---- verif/awsc_ext_dev.sv ----
`timescale 1ns/1ps
// -----------
// Slow memory
// -----------
module awsc_ext_dev (
	input wire logic sys_clk,
	input wire logic access_active,
	input wire logic [3:0] stall,
	output logic ext_ready_n
);
	logic [4:0] cnt;
	always_ff @(posedge sys_clk) begin
		cnt <= access_active ? cnt + {4'h0, cnt != 5'h1F} : 5'h00;
	end
	assign ext_ready_n = !(access_active && cnt >= {1'b0, stall});
endmodule

// ---- verif/awsc_props.sv ----
`timescale 1ns/1ps
// ------
// Checks
// ------
module awsc_props
	import awsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic ext_ready_n,
	input wire logic access_active,
	input wire logic access_done
);
	logic [31:0] shd;
	wire rd_ok = avs_read && !avs_waitrequest;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shd <= AWSC_WAIT_CTRL_MASK;
		end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
			shd <= avs_writedata & AWSC_WAIT_CTRL_MASK;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_ack;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	AST_ACK: assert property ($rose(avs_read || avs_write) |-> s_ack) else $error("late answer");
	AST_IDLE: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("idle wait");
	AST_RDVAL: assert property (rd_ok && avs_address == 4'h0 |-> (avs_readdata & AWSC_WAIT_CTRL_MASK) == shd)
		else $error("wait fields wrong");
	AST_UNMAP: assert property (rd_ok && avs_address == 4'hC |-> avs_readdata == 32'h0) else $error("unmapped");
	AST_HOLD: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
	AST_DONE: assert property (access_done |=> !access_done) else $error("long done");
	AST_DONE_ACT: assert property (access_done |-> $past(access_active)) else $error("stray done");
	AST_FINISH: assert property ($rose(access_active) |-> ##[1:400] access_done) else $error("hung access");
endmodule
bind awsc_top awsc_props u_props (.*);

// ---- verif/awsc_top_tb.sv ----
`timescale 1ns/1ps
module awsc_top_tb;
	logic sys_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, ext_ready_n, access_active, access_done;
	logic [3:0] avs_address = 4'h0, stall = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
	int miscompares = 0, tests_run = 0, base, n, m, a;
	int tbl[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
	int ars[3] = '{1, 0, 2};
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %0d got %0d", nm, e, g); end end
	awsc_top uut (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ext_ready_n(ext_ready_n),
		.access_active(access_active),
		.access_done(access_done)
	);
	awsc_ext_dev dev (
		.sys_clk(sys_clk),
		.access_active(access_active),
		.stall(stall),
		.ext_ready_n(ext_ready_n)
	);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
		int i = 0;
		@(posedge sys_clk);
		avs_address <= ad;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge sys_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		if (avs_waitrequest !== 1'b0) begin
			miscompares++;
			wrap_up();
		end
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic meas(input int ar, fk, bm, code, st);
		int i;
		bus(1'b1, 4'h0, code << (ar == 0 ? 13 : ar == 1 ? 23 : 26));
		stall <= st[3:0];
		bus(1'b1, 4'h4, 1 | ar << 4 | fk << 8 | bm << 12);
		n = 0;
		for (i = 0; i < 600 && access_done !== 1'b1; i++) begin
			@(negedge sys_clk);
			n += (access_active === 1'b1);
		end
		if (access_done !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		`CHK("reset fields", 32'h1F80_E000, rdv & 32'h1F80_E000)
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		`CHK("cleared fields", 32'h0, rdv & 32'h1F80_E000)
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0);
		`CHK("unmapped read", 32'h0, rdv)
		$display("register test ended");
		for (a = 0; a < 24; a++) begin
			meas(ars[a / 8], 0, a < 16 ? 0 : 2, a % 8, 0);
			if (a % 8 == 0) base = n;
			`CHK("wait count", a < 16 ? tbl[a % 8] : 2 * (a % 8), n - base)
		end
		bus(1'b0, 4'h4, 32'h0);
		`CHK("access readback", 32'h0000_2020, rdv)
		bus(1'b0, 4'h8, 32'h0);
		`CHK("status idle", 32'h0, rdv)
		meas(0, 0, 0, 0, 0);
		m = n;
		meas(0, 1, 0, 6, 0);
		`CHK("multiplexed", 12, n - m)
		$display("wait table test ended");
		meas(1, 0, 0, 1, 0);
		m = n;
		meas(1, 0, 0, 1, 8);
		`CHK("ready stretch", 1, n > m)
		meas(1, 0, 0, 0, 0);
		m = n;
		meas(1, 0, 0, 0, 8);
		`CHK("ready ignored", m, n)
		meas(0, 2, 0, 1, 0);
		m = n;
		meas(0, 2, 0, 1, 8);
		`CHK("sdram no ready", m, n)
		$display("ready test ended");
		wrap_up();
	end
endmodule
